// ---- core/tcp_pkg.sv ----
// Shared constants for the timer/counter with the shared prescaler.
// Assumes four oscillator clocks, one per phase, in each instruction cycle.
package tcp_pkg;

    // File address of the count register.
    localparam logic [4:0] TCP_CNT_ADDR   = 5'h01;

    // Field positions inside the option control register.
    localparam int         TCP_OPT_TCS    = 5;
    localparam int         TCP_OPT_SE     = 4;
    localparam int         TCP_OPT_PSA    = 3;
    localparam int         TCP_OPT_PS_HI  = 2;
    localparam int         TCP_OPT_PS_LO  = 0;

    // Reset values and the mask of implemented option bits.
    localparam logic [7:0] TCP_OPT_RESET  = 8'h3F;
    localparam logic [7:0] TCP_OPT_MASK   = 8'h3F;
    localparam logic [7:0] TCP_CNT_RESET  = 8'h00;
    localparam logic [7:0] TCP_PS_RESET   = 8'h00;

    // Instruction cycles of suppressed counting after a count write.
    localparam logic [1:0] TCP_INHIBIT    = 2'h2;

    // Internal phase clocks, one oscillator clock each.
    typedef enum logic [3:0] {
        TCP_Q1 = 4'b0001,
        TCP_Q2 = 4'b0010,
        TCP_Q3 = 4'b0100,
        TCP_Q4 = 4'b1000
    } tcp_phase_e;

endpackage : tcp_pkg

// ---- core/tcp_prescaler.sv ----
// The single 8-bit prescaler counter shared by timer and watchdog.
// Assumes the user end decides who advances it and when it clears.
`timescale 1ns/1ps
module tcp_prescaler #(
    parameter int PS_W = 8
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic srst,
    // Prescaler control and outputs.
    tcp_ps_if.owner  ps
);

    // The ratio field indexes eight stages, so only 8 bits can work.
    if (PS_W != 8) begin : g_width_check
        $error("tcp_prescaler needs PS_W of 8");
    end

    logic [PS_W-1:0] count_ff;   // Stage bits of the divider.
    logic [PS_W-1:0] nxt_count;  // Next divider value.
    logic [PS_W-1:0] low_mask;   // Stages below the selected one.

    ////////////////////////////////////////////////////////////////////////
    // Counting. A clear beats an advance in the same clock.
    always_comb begin
        nxt_count = count_ff;
        if (srst || ps.clear) begin
            nxt_count = tcp_pkg::TCP_PS_RESET;
        end else if (ps.count_en) begin
            nxt_count = count_ff + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        count_ff <= nxt_count;
    end

    ////////////////////////////////////////////////////////////////////////
    // Taps. The selected bit toggles every 2^ratio advances, so its
    // rising edge comes every 2^(ratio+1) advances.
    always_comb begin
        low_mask = PS_W'((32'h1 << ps.ratio) - 32'h1);
    end

    assign ps.value    = count_ff;
    assign ps.sel_bit  = count_ff[ps.ratio];
    assign ps.tc_wdt   = ps.count_en && ((count_ff & low_mask) == low_mask);
    assign ps.tc_timer = ps.tc_wdt && !count_ff[ps.ratio];

endmodule : tcp_prescaler

// ---- core/tcp_ps_if.sv ----
// Carrier between the timer core and its shared prescaler counter.
// Assumes both ends share one clock; all signals are combinational.
`timescale 1ns/1ps
interface tcp_ps_if;
    logic       clear;     // Clear the prescaler this clock.
    logic       count_en;  // Advance the prescaler this clock.
    logic [2:0] ratio;     // Selected ratio field.
    logic [7:0] value;     // Current prescaler count.
    logic       sel_bit;   // Selected output bit, symmetrical.
    logic       tc_timer;  // Selected bit rises on this advance.
    logic       tc_wdt;    // Postscaler terminal count for watchdog.

    modport owner (input clear, input count_en, input ratio,
                   output value, output sel_bit, output tc_timer,
                   output tc_wdt);
    modport user  (output clear, output count_en, output ratio,
                   input value, input sel_bit, input tc_timer,
                   input tc_wdt);
endinterface : tcp_ps_if

// ---- core/tcp_timer.sv ----
// Timer/counter with a shared 8-bit prescaler, top level.
// Assumes the instruction unit drives its strobes in phase Q4 and that
// all pins are synchronous to clock; the watchdog itself sits outside.
//
// How it works
// - Select zero counts every instruction cycle.
// - Count write suppresses counting two cycles.
// - Select one counts external input edges.
// - Edge select zero rising, one falling.
// - Prescaler serves timer or watchdog, never both.
// - Timer ratio is two to field plus one.
// - One 8-bit counter: prescaler or postscaler.
// - Prescaler value has no register address.
// - Count writes clear prescaler when timer-assigned.
// - Watchdog clear clears prescaler when watchdog-assigned.
// - Any reset clears the prescaler.
// - Counter mode samples on phases Q2, Q4.
// - Without prescaler, pin feeds synchroniser directly.
// - With prescaler, pin divided before synchronising.
// - Counter increments shortly after the edge.
// - Count register eight bits, address one, kept.
`timescale 1ns/1ps
module tcp_timer (
    // Clock and power-on reset.
    input  wire logic       clock,
    input  wire logic       srst,
    // External and watchdog reset, a level.
    input  wire logic       dev_reset,
    // File write port from the instruction unit.
    input  wire logic       file_wr_en,
    input  wire logic [4:0] file_addr,
    input  wire logic [7:0] file_wdata,
    // Option write and watchdog clear from the instruction unit.
    input  wire logic       option_wr_en,
    input  wire logic [7:0] option_wdata,
    input  wire logic       watchdog_clear_op,
    // Count pin and raw watchdog time-out tick.
    input  wire logic       external_count_input,
    input  wire logic       wdt_tick,
    // Register read-back and watchdog time-out, postscaled when the watchdog owns the prescaler.
    output logic [7:0]      timer_count_value_ff,
    output logic [7:0]      timer_option_control_ff,
    output logic            wdt_timeout_ff
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations.
    tcp_pkg::tcp_phase_e phase_ff;    // Current internal phase.
    tcp_pkg::tcp_phase_e nxt_phase;   // Next internal phase.
    logic [7:0] nxt_option;           // Next option register value.
    logic [7:0] nxt_count;            // Next count register value.
    logic [1:0] inhib_ff;             // Cycles of suppression left.
    logic [1:0] nxt_inhib;            // Next suppression count.
    logic       edge_prev_ff;         // Edge-adjusted pin, last clock.
    logic       samp_ff;              // Last phase sample of the source.
    logic       nxt_samp;             // Next phase sample.
    logic       nxt_wdt_timeout;      // Next watchdog time-out pulse.
    logic       is_q4;                // Last phase of the cycle.
    logic       sample_now;           // A sampling phase.
    logic       cnt_wr;               // Count register write taken.
    logic       tcs;                  // Counter mode when set.
    logic       prescaler_assign_bit;                  // Prescaler given to watchdog.
    logic       edge_src;             // Pin with counting edge rising.
    logic       ext_rise;             // Counting edge on the pin.
    logic       sync_src;             // Level fed to the synchroniser.
    logic       sync_rise;            // Rise seen at a sampling phase.
    logic       inc_event;            // Source asks for an increment.
    logic       rst_level;            // Source level under reset option.

    tcp_ps_if ps ();                  // Link to the prescaler.

    tcp_prescaler #(
        .PS_W (8)
    ) u_prescaler (
        .clock (clock),
        .srst  (srst),
        .ps    (ps.owner)
    );

    ////////////////////////////////////////////////////////////////////////
    // Decodes shared by the processes below.
    assign is_q4      = (phase_ff == tcp_pkg::TCP_Q4);
    assign sample_now = (phase_ff == tcp_pkg::TCP_Q2) || is_q4;
    assign tcs        = timer_option_control_ff[tcp_pkg::TCP_OPT_TCS];
    assign prescaler_assign_bit        = timer_option_control_ff[tcp_pkg::TCP_OPT_PSA];
    // Only the count register decodes here; the prescaler has no
    // address and cannot be read or written.
    assign cnt_wr     = file_wr_en && is_q4 &&
                        (file_addr == tcp_pkg::TCP_CNT_ADDR);

    // Folding the edge select into the pin lets one rising-edge
    // detector serve both edges.
    assign edge_src = external_count_input ^
                      timer_option_control_ff[tcp_pkg::TCP_OPT_SE];
    assign ext_rise = edge_src && !edge_prev_ff;
    // Any reset sets the edge select, which flips the adjusted pin; both
    // detectors are preloaded with that level so no false edge follows.
    assign rst_level = external_count_input ^
                       tcp_pkg::TCP_OPT_RESET[tcp_pkg::TCP_OPT_SE];

    ////////////////////////////////////////////////////////////////////////
    // Phase generator: four oscillator clocks make one cycle.
    always_comb begin
        unique case (phase_ff)
            tcp_pkg::TCP_Q1: nxt_phase = tcp_pkg::TCP_Q2;
            tcp_pkg::TCP_Q2: nxt_phase = tcp_pkg::TCP_Q3;
            tcp_pkg::TCP_Q3: nxt_phase = tcp_pkg::TCP_Q4;
            tcp_pkg::TCP_Q4: nxt_phase = tcp_pkg::TCP_Q1;
            default:         nxt_phase = tcp_pkg::TCP_Q1;
        endcase
        if (srst) begin
            nxt_phase = tcp_pkg::TCP_Q1;
        end
    end

    always_ff @(posedge clock) begin
        phase_ff <= nxt_phase;
    end

    ////////////////////////////////////////////////////////////////////////
    // Option register. Any reset returns it to all ones, which hands
    // the prescaler to the watchdog at the largest ratio.
    always_comb begin
        nxt_option = timer_option_control_ff;
        if (srst || dev_reset) begin
            nxt_option = tcp_pkg::TCP_OPT_RESET;
        end else if (option_wr_en && is_q4) begin
            nxt_option = option_wdata & tcp_pkg::TCP_OPT_MASK;
        end
    end

    always_ff @(posedge clock) begin
        timer_option_control_ff <= nxt_option;
    end

    ////////////////////////////////////////////////////////////////////////
    // Prescaler steering. The one counter has one source at a time.
    always_comb begin
        ps.ratio = timer_option_control_ff[tcp_pkg::TCP_OPT_PS_HI:
                                           tcp_pkg::TCP_OPT_PS_LO];
        // Clears: any reset, timer writes, or a watchdog clear.
        ps.clear = dev_reset
                 || (cnt_wr && !prescaler_assign_bit)
                 || (watchdog_clear_op && is_q4 && prescaler_assign_bit);
        if (prescaler_assign_bit) begin
            // Postscaler for the watchdog time-out ticks.
            ps.count_en = wdt_tick;
        end else if (tcs) begin
            // Divides the pin ahead of the synchroniser.
            ps.count_en = ext_rise;
        end else begin
            // Divides the instruction cycle.
            ps.count_en = is_q4;
        end
    end

    // Watchdog sees the postscaled tick only when it owns the counter.
    always_comb begin
        nxt_wdt_timeout = prescaler_assign_bit ? ps.tc_wdt : wdt_tick;
        if (srst) begin
            nxt_wdt_timeout = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        wdt_timeout_ff <= nxt_wdt_timeout;
    end

    ////////////////////////////////////////////////////////////////////////
    // Synchroniser for counter mode. The source is the pin itself or
    // the symmetrical prescaler tap; it is looked at only in Q2 and Q4,
    // so pulses shorter than two oscillator clocks may be missed.
    always_comb begin
        sync_src  = prescaler_assign_bit ? edge_src : ps.sel_bit;
        sync_rise = sample_now && sync_src && !samp_ff;
        nxt_samp  = sample_now ? sync_src : samp_ff;
        if (srst || dev_reset) begin
            nxt_samp = rst_level;
        end
    end

    always_ff @(posedge clock) begin
        samp_ff      <= nxt_samp;
        edge_prev_ff <= (srst || dev_reset) ? rst_level : edge_src;
    end

    ////////////////////////////////////////////////////////////////////////
    // Count register and its write suppression.
    always_comb begin
        if (tcs) begin
            // Lands at the sampling phase after the edge, not on it.
            inc_event = sync_rise;
        end else begin
            inc_event = is_q4 && (prescaler_assign_bit || ps.tc_timer);
        end
    end

    // Suppression counts whole instruction cycles, ending on Q4.
    always_comb begin
        nxt_inhib = inhib_ff;
        if (srst || dev_reset) begin
            nxt_inhib = 2'h0;
        end else if (cnt_wr) begin
            nxt_inhib = tcp_pkg::TCP_INHIBIT;
        end else if (is_q4 && (inhib_ff != 2'h0)) begin
            nxt_inhib = inhib_ff - 2'h1;
        end
    end

    // A write wins over an increment in the same clock. The external
    // and watchdog reset leave the value alone.
    always_comb begin
        nxt_count = timer_count_value_ff;
        if (srst) begin
            nxt_count = tcp_pkg::TCP_CNT_RESET;
        end else if (cnt_wr) begin
            nxt_count = file_wdata;
        end else if (inc_event && (inhib_ff == 2'h0)) begin
            nxt_count = timer_count_value_ff + 8'h01;
        end
    end

    always_ff @(posedge clock) begin
        inhib_ff             <= nxt_inhib;
        timer_count_value_ff <= nxt_count;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks. Helper state tracks clocks since the last count write.
    logic [3:0] since_wr_ff;   // Clocks since the last write, saturating.
    logic [7:0] last_wr_ff;    // Value of the last write.

    always_ff @(posedge clock) begin
        // Reset saturates the count, so no write is taken as recent.
        if (srst) begin
            since_wr_ff <= 4'hF;
        end else if (cnt_wr) begin
            since_wr_ff <= 4'h0;
        end else if (since_wr_ff != 4'hF) begin
            since_wr_ff <= since_wr_ff + 4'h1;
        end
        if (cnt_wr) begin
            last_wr_ff <= file_wdata;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    sequence wr_timer_s;
        cnt_wr && !prescaler_assign_bit;
    endsequence

    sequence wdt_clr_s;
        watchdog_clear_op && is_q4 && prescaler_assign_bit;
    endsequence

    write_load_a: assert property (
        cnt_wr |=> timer_count_value_ff == $past(file_wdata))
        else $error("count write not loaded");

    write_hold_a: assert property (
        (since_wr_ff >= 4'h1 && since_wr_ff <= 4'h9 && !dev_reset)
        |-> timer_count_value_ff == last_wr_ff)
        else $error("count moved during write suppression");

    resume_a: assert property (
        (since_wr_ff == 4'hC && prescaler_assign_bit && !tcs && $stable(prescaler_assign_bit) && $stable(tcs))
        |-> timer_count_value_ff == last_wr_ff + 8'h01)
        else $error("count did not resume after suppression");

    timer_step_a: assert property (
        (is_q4 && !tcs && prescaler_assign_bit && inhib_ff == 2'h0 && !cnt_wr)
        |=> timer_count_value_ff == $past(timer_count_value_ff) + 8'h01)
        else $error("timer mode missed a cycle increment");

    count_wrap_a: assert property (
        (timer_count_value_ff == 8'hFF && inc_event && inhib_ff == 2'h0
         && !cnt_wr) |=> timer_count_value_ff == 8'h00)
        else $error("count did not wrap to zero");

    ratio_step_a: assert property (
        (is_q4 && !tcs && !prescaler_assign_bit && inhib_ff == 2'h0 && !cnt_wr)
        |=> timer_count_value_ff == $past(timer_count_value_ff)
            + {7'h00, $past(ps.tc_timer)})
        else $error("prescaled step wrong");

    mid_phase_a: assert property (
        (tcs && !sample_now && !cnt_wr) |=> $stable(timer_count_value_ff))
        else $error("counter moved outside sampling phase");

    ps_wr_clear_a: assert property (
        wr_timer_s |=> ps.value == 8'h00)
        else $error("count write did not clear prescaler");

    ps_wdt_clear_a: assert property (
        wdt_clr_s |=> ps.value == 8'h00)
        else $error("watchdog clear did not clear prescaler");

    ps_owner_a: assert property (
        ((prescaler_assign_bit && !wdt_tick && !dev_reset && !(watchdog_clear_op && is_q4))
         |=> $stable(ps.value))
        and (wdt_clr_s |=> ps.value == 8'h00))
        else $error("timer side touched watchdog prescaler");

    reset_clear_a: assert property (
        dev_reset |=> (ps.value == 8'h00 &&
                       timer_option_control_ff == 8'h3F))
        else $error("reset left prescaler or option set");

endmodule : tcp_timer

// ---- test/tb_top.sv ----
// Self-checking bench for the timer with the shared prescaler.
// Assumes the instruction phase starts at Q1 on the first clock after
// reset release; the bench tracks the phase by counting clocks.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        n_fail++; \
        $display("mismatch %s exp %0h got %0h", nm, exp, got); \
    end \
end
module tb_top;
    // Design stimulus and observation.
    logic       clock, srst, dev_reset;
    logic       file_wr_en, option_wr_en, watchdog_clear_op, wdt_tick;
    logic [4:0] file_addr;
    logic [7:0] file_wdata, option_wdata, c0;
    logic [7:0] timer_count_value_ff, timer_option_control_ff;
    logic       wdt_timeout_ff, ext_pin;
    int         cnt, n_to, n_fail, samples_checked;

    tcp_timer i_dut (.clock(clock), .srst(srst), .dev_reset(dev_reset),
        .file_wr_en(file_wr_en), .file_addr(file_addr),
        .file_wdata(file_wdata), .option_wr_en(option_wr_en),
        .option_wdata(option_wdata),
        .watchdog_clear_op(watchdog_clear_op),
        .external_count_input(ext_pin), .wdt_tick(wdt_tick),
        .timer_count_value_ff(timer_count_value_ff),
        .timer_option_control_ff(timer_option_control_ff),
        .wdt_timeout_ff(wdt_timeout_ff));
    tcp_ext_src i_src (.clock(clock), .pin(ext_pin));

    ////////////////////////////////////////////////////////////////////
    // Clock, phase tracker and time-out pulse counter.
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // Clocks since release; a value of 3 mod 4 means the next edge is Q4.
    always @(posedge clock) cnt <= srst ? 0 : cnt + 1;
    // Time-out pulses last one clock, so each is seen once here.
    always @(negedge clock) if (wdt_timeout_ff === 1'b1) n_to++;

    ////////////////////////////////////////////////////////////////////
    // Access tasks. Strobes are only taken in Q4, so wait for it.
    task automatic cycles(input int n);
        repeat (n) @(negedge clock);
    endtask : cycles

    // kind 0 writes a file, 1 the option register, 2 clears watchdog.
    task automatic wr(input int kind, input logic [4:0] a,
                      input logic [7:0] d);
        while (cnt % 4 != 3) @(negedge clock);
        file_wr_en        = (kind == 0);
        option_wr_en      = (kind == 1);
        watchdog_clear_op = (kind == 2);
        file_addr         = a;
        file_wdata        = d;
        option_wdata      = d;
        @(negedge clock);
        file_wr_en        = 1'b0;
        option_wr_en      = 1'b0;
        watchdog_clear_op = 1'b0;
    endtask : wr

    task automatic tick(input int n);
        repeat (n) begin
            wdt_tick = 1'b1;
            @(negedge clock);
            wdt_tick = 1'b0;
            cycles(2);
        end
    endtask : tick

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict

    // A hang is cut short well beyond the roughly 4400 clocks needed.
    initial begin
        #(20000 * 25);
        n_fail++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        {srst, dev_reset, file_wr_en, option_wr_en} = 4'hF;
        {watchdog_clear_op, wdt_tick} = 2'b00;
        dev_reset = 1'b0;
        {file_wr_en, option_wr_en} = 2'b00;
        file_addr = 5'h00;
        {file_wdata, option_wdata} = 16'h0000;
        {n_to, n_fail, samples_checked} = '0;
        repeat (3) @(posedge clock);
        @(negedge clock);
        srst = 1'b0;
        `CHK("opt reset", 8'h3F, timer_option_control_ff)
        `CHK("cnt reset", 8'h00, timer_count_value_ff)
        // Timer mode without prescaler; upper option bits read as 0.
        wr(1, 5'h00, 8'hC8);
        `CHK("opt", 8'h08, timer_option_control_ff)
        wr(0, 5'h01, 8'hFE);
        `CHK("cnt wr", 8'hFE, timer_count_value_ff)
        cycles(11);
        `CHK("cnt held", 8'hFE, timer_count_value_ff)
        cycles(1);
        `CHK("cnt inc", 8'hFF, timer_count_value_ff)
        cycles(4);
        `CHK("cnt wrap", 8'h00, timer_count_value_ff)
        // Another address leaves the count alone and it still runs.
        wr(0, 5'h02, 8'h55);
        `CHK("cnt addr", 8'h01, timer_count_value_ff)
        // Every ratio: 2 increments over twice the ratio in cycles.
        for (int r = 0; r < 8; r++) begin
            wr(1, 5'h00, 8'(r));
            `CHK("opt ratio", 8'(r), timer_option_control_ff)
            wr(0, 5'h01, 8'h00);
            cycles(8);
            c0 = timer_count_value_ff;
            cycles(8 << (r + 1));
            `CHK("ps ratio", c0 + 8'h02, timer_count_value_ff)
        end
        // Counter mode without prescaler: rising, then falling edges.
        wr(1, 5'h00, 8'h28);
        c0 = timer_count_value_ff;
        i_src.drive(1'b1);
        cycles(4);
        `CHK("cnt rise", c0 + 8'h01, timer_count_value_ff)
        i_src.drive(1'b0);
        cycles(4);
        `CHK("cnt fall ign", c0 + 8'h01, timer_count_value_ff)
        wr(1, 5'h00, 8'h38);
        i_src.drive(1'b1);
        cycles(4);
        `CHK("cnt rise ign", c0 + 8'h01, timer_count_value_ff)
        i_src.drive(1'b0);
        cycles(4);
        `CHK("cnt fall", c0 + 8'h02, timer_count_value_ff)
        // Counter mode through the prescaler at 1:4.
        wr(1, 5'h00, 8'h21);
        wr(0, 5'h01, 8'h00);
        cycles(12);
        i_src.pulses(8);
        cycles(8);
        `CHK("cnt ps", 8'h02, timer_count_value_ff)
        // Hand the prescaler to the watchdog the safe way, ratio 4.
        wr(2, 5'h00, 8'h00);
        wr(0, 5'h01, 8'h00);
        wr(1, 5'h00, 8'h0A);
        wr(2, 5'h00, 8'h00);
        n_to = 0;
        tick(3);
        `CHK("wdt pre", 0, n_to)
        wr(2, 5'h00, 8'h00);
        tick(1);
        `CHK("wdt clr", 0, n_to)
        tick(3);
        `CHK("wdt post", 1, n_to)
        // Back to the timer: the watchdog then sees every tick.
        wr(2, 5'h00, 8'h00);
        wr(1, 5'h00, 8'h02);
        n_to = 0;
        tick(3);
        `CHK("wdt direct", 3, n_to)
        // Device reset restores the option but keeps the count.
        wr(1, 5'h00, 8'h28);
        c0 = timer_count_value_ff;
        dev_reset = 1'b1;
        cycles(1);
        dev_reset = 1'b0;
        cycles(1);
        `CHK("opt dev rst", 8'h3F, timer_option_control_ff)
        `CHK("cnt kept", c0, timer_count_value_ff)
        print_verdict();
    end
endmodule : tb_top

// ---- test/tcp_ext_src.sv ----
// Behavioural model of the pulse source that drives the count pin.
// Assumes the bench calls its tasks from a falling clock edge.
`timescale 1ns/1ps
module tcp_ext_src (
    // Oscillator clock, used only to pace the pin.
    input  wire logic clock,
    // Count pin towards the timer.
    output logic      pin
);
    // The pin idles low, the way a grounded source would.
    initial begin
        pin = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // Change the pin level at the next falling edge, then hold it.
    task automatic drive(input logic v);
        @(negedge clock);
        pin = v;
    endtask : drive

    // Send n whole pulses, each level held three clocks. Shorter than
    // two clocks per level could slip past the two-phase sampling.
    task automatic pulses(input int n);
        repeat (n) begin
            drive(1'b1);
            repeat (2) @(negedge clock);
            drive(1'b0);
            repeat (2) @(negedge clock);
        end
    endtask : pulses
endmodule : tcp_ext_src
